/* rtl/dclh_regs.vh */
// Constants of the disk command-list host port: list layout, flags, timing
`ifndef DCLH_REGS_VH
`define DCLH_REGS_VH
// ****************************************
// Command list word offsets
// ****************************************
`define DCLH_W_STAT0 4'h0
`define DCLH_W_STAT1 4'h1
`define DCLH_W_CMD 4'h2
`define DCLH_W_DADR_HI 4'h3
`define DCLH_W_DADR_LO 4'h4
`define DCLH_W_LEN 4'h5
`define DCLH_W_MAP 4'h6
`define DCLH_W_MADR 4'h7
`define DCLH_W_CHAIN_HI 4'h8
`define DCLH_W_CHAIN_LO 4'h9
`define DCLH_LIST_WORDS 4'ha
// ****************************************
// Field positions
// ****************************************
`define DCLH_CMD_CODE_HI 15
`define DCLH_CMD_CODE_LO 8
`define DCLH_VERIFY_BIT 9
`define DCLH_INTEN_BIT 7
`define DCLH_PHYS_BIT 15
`define DCLH_DONE_BIT 15
`define DCLH_FAULT_BIT 14
`define DCLH_CHAIN_END 20'h00000
// ****************************************
// Serial I/O bus command codes
// ****************************************
`define DCLH_SIO_NOP 2'h0
`define DCLH_SIO_ADDR 2'h1
`define DCLH_SIO_RESET 2'h2
// ****************************************
// Timing
// ****************************************
`define DCLH_CLK_MHZ 100
`define DCLH_DMA_WAIT_US 100
`endif

/* rtl/dclh_sio_shift.v */
// Serial I/O bus receiver: collects one 20-bit list address bit by bit
`timescale 1ns/1ps
module dclh_sio_shift (
   input wire mclk,
   input wire arst_n,
   input wire sio_bit_valid,
   input wire sio_bit,
   input wire sio_clear,
   output reg [19:0] sio_word_q,
   output reg [4:0] sio_count_q
);
   // ****************************************
   // Shift register, MSB first
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sio_word_q <= 20'h00000;
         sio_count_q <= 5'h00;
      end else if (sio_clear) begin
         sio_count_q <= 5'h00;
      end else if (sio_bit_valid && sio_count_q != 5'h14) begin
         sio_word_q <= {sio_word_q[18:0], sio_bit};
         sio_count_q <= sio_count_q + 5'h01;
      end
   end
endmodule // dclh_sio_shift

/* rtl/dclh_port.v */
// Command-list host port: takes a list address, fetches, executes, writes back
`timescale 1ns/1ps
`include "dclh_regs.vh"
// How it works
// - Address over serial bus, acknowledged when idle
// - Busy while processing; new address refused
// - Serial bus reset returns port to idle
// - Set done flag in word 0
// - Hung command stays busy until reset
// - Interrupt on completion only when enabled
// - Flags written into words 0 and 1
// - Twelve of thirteen single-bit status flags reported (not bit 12)
// - Drive and command decoded from word 2
// - Host address from words 6 and 7
// - Disk address from words 3 and 4
// - Actual byte count written to word 5
// - Drive status from sampled drive lines
// - Twenty-bit DMA address, four-bit map
// - Code in high byte, unit low bits
// - Bit 9 requests verify on data commands
// - Words 8 and 9 chain next list
// - Word 3 MSB marks physical addressing
module dclh_port (
   input wire mclk,
   input wire arst_n,
   input wire [1:0] sio_cmd,
   input wire sio_bit_valid,
   input wire sio_bit,
   output wire sio_ack,
   output wire sio_refuse,
   output wire busy,
   output reg dma_req_q,
   output reg dma_we_q,
   output reg [19:0] dma_addr_q,
   output reg [15:0] dma_wdata_q,
   input wire dma_ack,
   input wire [15:0] dma_rdata,
   output reg cmd_start_q,
   output reg [7:0] cmd_code_q,
   output reg [1:0] cmd_unit_q,
   output reg cmd_verify_q,
   output reg cmd_phys_q,
   output reg [31:0] cmd_disk_addr_q,
   output reg [19:0] cmd_host_addr_q,
   output reg [15:0] cmd_len_q,
   input wire cmd_done,
   input wire [12:0] cmd_flags,
   input wire [15:0] cmd_actual_len,
   input wire [7:0] drive_lines,
   output reg host_irq_q
);
   localparam ST_IDLE = 3'h0;
   localparam ST_FETCH = 3'h1;
   localparam ST_EXEC = 3'h2;
   localparam ST_WLEN = 3'h3;
   localparam ST_WST1 = 3'h4;
   localparam ST_WST0 = 3'h5;
   localparam ST_NEXT = 3'h6;

   reg [2:0] state_q;
   reg [19:0] list_base_q;
   reg [3:0] word_idx_q;
   reg [15:0] list_q [0:9];
   reg [12:0] flags_q;
   reg [7:0] drv_stat_q;
   wire sio_clear;
   wire [19:0] sio_word;
   wire [4:0] sio_count;
   wire addr_go;
   wire [19:0] chain_ptr;

   // Address of list word n: word-aligned byte addressing
   function [19:0] word_addr;
      input [19:0] base;
      input [3:0] idx;
      begin
         word_addr = base + {15'h0000, idx, 1'b0};
      end
   endfunction

   // ****************************************
   // Serial I/O bus receive and handshake
   // ****************************************
   dclh_sio_shift u_shift (
      .mclk(mclk),
      .arst_n(arst_n),
      .sio_bit_valid(sio_bit_valid),
      .sio_bit(sio_bit),
      .sio_clear(sio_clear),
      .sio_word_q(sio_word),
      .sio_count_q(sio_count)
   );

   assign busy = (state_q != ST_IDLE);
   assign addr_go = (sio_cmd == `DCLH_SIO_ADDR) && (sio_count == 5'h14);
   assign sio_ack = addr_go && !busy;
   assign sio_refuse = addr_go && busy;
   assign sio_clear = (sio_cmd != `DCLH_SIO_NOP);
   assign chain_ptr = {list_q[`DCLH_W_CHAIN_HI][3:0], list_q[`DCLH_W_CHAIN_LO]};

   // ****************************************
   // Sequencer: fetch, execute, write back
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         list_base_q <= 20'h00000;
         word_idx_q <= 4'h0;
         dma_req_q <= 1'b0;
         dma_we_q <= 1'b0;
         dma_addr_q <= 20'h00000;
         dma_wdata_q <= 16'h0000;
         cmd_start_q <= 1'b0;
         flags_q <= 13'h0000;
         drv_stat_q <= 8'h00;
         host_irq_q <= 1'b0;
      end else if (sio_cmd == `DCLH_SIO_RESET) begin
         state_q <= ST_IDLE;
         dma_req_q <= 1'b0;
         dma_we_q <= 1'b0;
         cmd_start_q <= 1'b0;
         host_irq_q <= 1'b0;
      end else begin
         cmd_start_q <= 1'b0;
         host_irq_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (sio_ack) begin
                  list_base_q <= {sio_word[19:1], 1'b0};
                  word_idx_q <= 4'h0;
                  dma_req_q <= 1'b1;
                  dma_we_q <= 1'b0;
                  dma_addr_q <= {sio_word[19:1], 1'b0};
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (dma_ack) begin
                  if (word_idx_q == `DCLH_LIST_WORDS - 4'h1) begin
                     dma_req_q <= 1'b0;
                     cmd_start_q <= 1'b1;
                     state_q <= ST_EXEC;
                  end else begin
                     word_idx_q <= word_idx_q + 4'h1;
                     dma_addr_q <= word_addr(list_base_q, word_idx_q + 4'h1);
                  end
               end
            end
            ST_EXEC: begin
               // A hung command simply keeps the port busy here
               if (cmd_done) begin
                  flags_q <= cmd_flags;
                  drv_stat_q <= drive_lines;
                  dma_req_q <= 1'b1;
                  dma_we_q <= 1'b1;
                  dma_addr_q <= word_addr(list_base_q, `DCLH_W_LEN);
                  dma_wdata_q <= cmd_actual_len;
                  state_q <= ST_WLEN;
               end
            end
            ST_WLEN: begin
               if (dma_ack) begin
                  dma_addr_q <= word_addr(list_base_q, `DCLH_W_STAT1);
                  dma_wdata_q <= {flags_q[4:0], 3'h0, drv_stat_q};
                  state_q <= ST_WST1;
               end
            end
            ST_WST1: begin
               if (dma_ack) begin
                  dma_addr_q <= word_addr(list_base_q, `DCLH_W_STAT0);
                  // Done flag goes last so the host never sees stale words
                  dma_wdata_q <= {1'b1, flags_q[11], flags_q[10:5], 8'h00};
                  state_q <= ST_WST0;
               end
            end
            ST_WST0: begin
               if (dma_ack) begin
                  dma_req_q <= 1'b0;
                  dma_we_q <= 1'b0;
                  host_irq_q <= list_q[`DCLH_W_CMD][`DCLH_INTEN_BIT];
                  state_q <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (chain_ptr != `DCLH_CHAIN_END) begin
                  list_base_q <= {chain_ptr[19:1], 1'b0};
                  word_idx_q <= 4'h0;
                  dma_req_q <= 1'b1;
                  dma_addr_q <= {chain_ptr[19:1], 1'b0};
                  state_q <= ST_FETCH;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Command list capture memory
   // ****************************************
   always @(posedge mclk) begin
      if (state_q == ST_FETCH && dma_ack) begin
         list_q[word_idx_q] <= dma_rdata;
      end
   end

   // ****************************************
   // Decoded command fields
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_code_q <= 8'h00;
         cmd_unit_q <= 2'h0;
         cmd_verify_q <= 1'b0;
         cmd_phys_q <= 1'b0;
         cmd_disk_addr_q <= 32'h00000000;
         cmd_host_addr_q <= 20'h00000;
         cmd_len_q <= 16'h0000;
      end else if (state_q == ST_FETCH && dma_ack
                   && word_idx_q == `DCLH_LIST_WORDS - 4'h1) begin
         cmd_code_q <= list_q[`DCLH_W_CMD][`DCLH_CMD_CODE_HI:`DCLH_CMD_CODE_LO];
         cmd_unit_q <= list_q[`DCLH_W_CMD][1:0];
         cmd_verify_q <= list_q[`DCLH_W_CMD][`DCLH_VERIFY_BIT];
         cmd_phys_q <= list_q[`DCLH_W_DADR_HI][`DCLH_PHYS_BIT];
         cmd_disk_addr_q <= {list_q[`DCLH_W_DADR_HI], list_q[`DCLH_W_DADR_LO]};
         cmd_host_addr_q <= {list_q[`DCLH_W_MAP][3:0], list_q[`DCLH_W_MADR][15:1], 1'b0};
         cmd_len_q <= list_q[`DCLH_W_LEN];
      end
   end
endmodule // dclh_port

/* test/dclh_port_asserts.sv */
// Checker of the command-list host port, bound to its ports
`timescale 1ns/1ps
module dclh_port_chk (
   input wire mclk,
   input wire arst_n,
   input wire [1:0] sio_cmd,
   input wire sio_ack,
   input wire sio_refuse,
   input wire busy,
   input wire dma_req_q,
   input wire dma_we_q,
   input wire [19:0] dma_addr_q,
   input wire [15:0] dma_wdata_q,
   input wire dma_ack,
   input wire cmd_start_q,
   input wire [19:0] cmd_host_addr_q,
   input wire cmd_done,
   input wire [15:0] cmd_actual_len,
   input wire host_irq_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_ack_when_idle: assert property (sio_ack |-> !busy && sio_cmd == 2'h1) else $error("ack while busy");
   a_refuse_busy: assert property (sio_cmd == 2'h1 && busy |-> sio_refuse && !sio_ack) else $error("busy not refused");
   a_fetch_follows: assert property (sio_ack |=> busy && dma_req_q && !dma_we_q) else $error("no fetch after ack");
   a_serial_reset: assert property (sio_cmd == 2'h2 |=> !busy && !dma_req_q && !host_irq_q) else $error("reset not idle");
   a_req_stands: assert property (dma_req_q && !dma_ack && sio_cmd != 2'h2 |=> dma_req_q && $stable(dma_addr_q) && $stable(dma_we_q)) else $error("request dropped");
   a_addr_even: assert property (dma_req_q |-> !dma_addr_q[0]) else $error("odd dma address");
   a_start_fields: assert property (cmd_start_q |-> busy && !cmd_host_addr_q[0] && !dma_req_q ##1 !cmd_start_q) else $error("bad start");
   a_len_first: assert property (cmd_done && busy && !dma_req_q && !cmd_start_q && sio_cmd == 2'h0 |=> dma_req_q && dma_we_q && dma_wdata_q == $past(cmd_actual_len)) else $error("length not written");
   a_irq_after_wb: assert property (host_irq_q |-> $past(dma_we_q) && !dma_req_q && !$past(host_irq_q)) else $error("stray interrupt");
endmodule // dclh_port_chk
bind dclh_port dclh_port_chk u_chk (.mclk(mclk), .arst_n(arst_n), .sio_cmd(sio_cmd), .sio_ack(sio_ack),
   .sio_refuse(sio_refuse), .busy(busy), .dma_req_q(dma_req_q), .dma_we_q(dma_we_q),
   .dma_addr_q(dma_addr_q), .dma_wdata_q(dma_wdata_q), .dma_ack(dma_ack), .cmd_start_q(cmd_start_q),
   .cmd_host_addr_q(cmd_host_addr_q), .cmd_done(cmd_done), .cmd_actual_len(cmd_actual_len),
   .host_irq_q(host_irq_q));

/* test/dclh_host_mem.sv */
// Host memory model answering the port's DMA word requests
`timescale 1ns/1ps
module dclh_host_mem (
   input wire mclk,
   input wire arst_n,
   input wire slow,
   input wire dma_req_q,
   input wire dma_we_q,
   input wire [19:0] dma_addr_q,
   input wire [15:0] dma_wdata_q,
   output reg dma_ack,
   output reg [15:0] dma_rdata
);
   reg [15:0] mem [0:1023];
   reg [1:0] wait_q;
   // One word per request, promptly or after a wait; idle bus toggles
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dma_ack <= 1'b0;
         wait_q <= 2'h0;
         dma_rdata <= 16'h5a5a;
      end else if (dma_req_q && !dma_ack && wait_q == 2'h0) begin
         dma_ack <= 1'b1;
         dma_rdata <= mem[dma_addr_q[10:1]];
         if (dma_we_q)
            mem[dma_addr_q[10:1]] <= dma_wdata_q;
         wait_q <= slow ? 2'h3 : 2'h0;
      end else begin
         dma_ack <= 1'b0;
         dma_rdata <= ~dma_rdata;
         if (wait_q != 2'h0 && dma_req_q)
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule // dclh_host_mem

/* test/tb_dclh_port.sv */
// Testbench of the command-list host port
`timescale 1ns/1ps
module tb_dclh_port;
   reg mclk = 1'b0, arst_n = 1'b0, sio_bit_valid = 1'b0, sio_bit = 1'b0, cmd_done = 1'b0, slow = 1'b0;
   reg [1:0] sio_cmd = 2'h0;
   reg [12:0] cmd_flags = 13'h0000;
   reg [15:0] cmd_actual_len = 16'h0000;
   reg [7:0] drive_lines = 8'h00;
   reg [31:0] seed = 32'hafe7;
   integer err_count = 0, checks = 0, irq_cnt = 0, i;
   localparam [15:0] sect_mask = 16'h00ff; // Bench sector length, 256 bytes less one
   wire sio_ack, sio_refuse, busy, dma_req_q, dma_we_q, dma_ack, cmd_start_q, cmd_verify_q, cmd_phys_q;
   wire host_irq_q;
   wire [19:0] dma_addr_q, cmd_host_addr_q;
   wire [15:0] dma_wdata_q, dma_rdata, cmd_len_q;
   wire [7:0] cmd_code_q;
   wire [1:0] cmd_unit_q;
   wire [31:0] cmd_disk_addr_q;
   dclh_port u_dut (.mclk(mclk), .arst_n(arst_n), .sio_cmd(sio_cmd), .sio_bit_valid(sio_bit_valid),
      .sio_bit(sio_bit), .sio_ack(sio_ack), .sio_refuse(sio_refuse), .busy(busy), .dma_req_q(dma_req_q),
      .dma_we_q(dma_we_q), .dma_addr_q(dma_addr_q), .dma_wdata_q(dma_wdata_q), .dma_ack(dma_ack),
      .dma_rdata(dma_rdata), .cmd_start_q(cmd_start_q), .cmd_code_q(cmd_code_q), .cmd_unit_q(cmd_unit_q),
      .cmd_verify_q(cmd_verify_q), .cmd_phys_q(cmd_phys_q), .cmd_disk_addr_q(cmd_disk_addr_q),
      .cmd_host_addr_q(cmd_host_addr_q), .cmd_len_q(cmd_len_q), .cmd_done(cmd_done),
      .cmd_flags(cmd_flags), .cmd_actual_len(cmd_actual_len), .drive_lines(drive_lines),
      .host_irq_q(host_irq_q));
   dclh_host_mem u_mem (.mclk(mclk), .arst_n(arst_n), .slow(slow), .dma_req_q(dma_req_q),
      .dma_we_q(dma_we_q), .dma_addr_q(dma_addr_q), .dma_wdata_q(dma_wdata_q), .dma_ack(dma_ack),
      .dma_rdata(dma_rdata));
   // Clock and interrupt pulse counter
   always #5 mclk = ~mclk;
   always @(posedge mclk) if (host_irq_q === 1'b1) irq_cnt <= irq_cnt + 1;
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [15:0] wd(input [19:0] b, input integer k);
      wd = u_mem.mem[b[10:1] + k];
   endfunction
   task tally_and_finish;
      begin
         $display("checks=%0d err_count=%0d", checks, err_count);
         if (err_count == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input [63:0] seen, input [63:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Random list with interrupt enable and chain pointer
   task build(input [19:0] b, input ie, input [19:0] nx);
      integer k;
      begin
         for (k = 1; k < 8; k = k + 1) begin
            seed = xs(seed);
            u_mem.mem[b[10:1] + k] = seed[15:0];
         end
         u_mem.mem[b[10:1]] = 16'h0000;
         u_mem.mem[b[10:1] + 2][7] = ie;
         u_mem.mem[b[10:1] + 5] = u_mem.mem[b[10:1] + 5] & ~sect_mask;
         u_mem.mem[b[10:1] + 7][0] = 1'b0;
         u_mem.mem[b[10:1] + 8] = {12'h000, nx[19:16]};
         u_mem.mem[b[10:1] + 9] = nx[15:0];
      end
   endtask
   // Shift 20 address bits MSB first, then request the transfer
   task send_addr(input [19:0] a, input ok);
      integer k;
      begin
         for (k = 19; k >= 0; k = k - 1) begin
            @(posedge mclk);
            sio_bit_valid <= 1'b1;
            sio_bit <= a[k];
         end
         @(posedge mclk);
         sio_bit_valid <= 1'b0;
         sio_cmd <= 2'h1;
         #1;
         check(busy, !ok);
         check({sio_ack, sio_refuse}, {ok, !ok});
         @(posedge mclk);
         sio_cmd <= 2'h0;
      end
   endtask
   task wait_start;
      integer k;
      begin
         k = 0;
         while (cmd_start_q !== 1'b1 && k < 400) begin
            @(posedge mclk);
            #1;
            k = k + 1;
         end
         check(k < 400, 1);
         if (k >= 400) tally_and_finish;
      end
   endtask
   // One command: fields, refusal while busy, completion, write-back
   task do_cmd(input [19:0] b, input ie, input rf);
      integer k, n0;
      reg [15:0] w2, w3, w7, al;
      reg [12:0] fl;
      reg [7:0] dl;
      begin
         n0 = irq_cnt;
         wait_start;
         w2 = wd(b, 2);
         w3 = wd(b, 3);
         w7 = wd(b, 7);
         check({cmd_code_q, cmd_verify_q, cmd_unit_q}, {w2[15:8], w2[9], w2[1:0]});
         check({cmd_phys_q, cmd_disk_addr_q}, {w3[15], w3, wd(b, 4)});
         check({cmd_host_addr_q, cmd_len_q}, {wd(b, 6) & 16'h000f, w7[15:1], 1'b0, wd(b, 5)});
         if (rf) send_addr(20'h00300, 1'b0);
         seed = xs(seed);
         {fl, al, dl} = {seed[12:0], seed[31:16], seed[7:0] ^ seed[20:13]};
         @(posedge mclk);
         {cmd_flags, cmd_actual_len, drive_lines, cmd_done} <= {fl, al, dl, 1'b1};
         @(posedge mclk);
         cmd_done <= 1'b0;
         k = 0;
         while (wd(b, 0) !== {1'b1, fl[11], fl[10:5], 8'h00} && k < 400) begin
            @(posedge mclk);
            k = k + 1;
         end
         check(k < 400, 1);
         repeat (3) @(posedge mclk);
         check({wd(b, 5), wd(b, 1)}, {al, fl[4:0], 3'b000, dl});
         check(irq_cnt - n0, ie);
         if (k >= 400) tally_and_finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         seed = xs(seed);
         slow <= seed[0];
         build(20'h00100, i[0], 20'h00200);
         build(20'h00200, !i[0], 20'h00000);
         send_addr(20'h00100, 1'b1);
         do_cmd(20'h00100, i[0], i < 2);
         do_cmd(20'h00200, !i[0], 1'b0);
         $display("test %0d done", i);
      end
      // Hung command stays busy until the serial reset
      build(20'h00100, 1'b1, 20'h00000);
      send_addr(20'h00100, 1'b1);
      wait_start;
      repeat (60) @(posedge mclk);
      check(busy, 1);
      sio_cmd <= 2'h2;
      @(posedge mclk);
      sio_cmd <= 2'h0;
      #1;
      check(busy, 0);
      send_addr(20'h00100, 1'b1);
      do_cmd(20'h00100, 1'b1, 1'b0);
      $display("test reset done");
      tally_and_finish;
   end
endmodule // tb_dclh_port
